// >>> inc/eisl_pkg.sv
`default_nettype none
package eisl_pkg;
    // =========================================================
    // Register map
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_PENDING = 8'h14;
    localparam logic [7:0] ADDR_CTRL = 8'h18;
    // =========================================================
    // Status bit positions
    localparam int BIT_CORE_DONE = 0;
    localparam int BIT_NEG_DONE = 1;
    localparam int BIT_RX_DONE = 2;
    localparam int BIT_RX_DROP = 3;
    localparam int BIT_RX_OVF = 4;
    localparam int BIT_TX_DONE = 5;
    localparam int BIT_CLK_LOCK = 6;
    localparam int BIT_XCVR_RDY = 7;
    localparam int BIT_PHY_DONE = 8;
    localparam int NUM_BITS = 9;
    // Control register fields
    localparam int CTRL_MCAST_REJ = 1;
    localparam int CTRL_BCAST_REJ = 2;
    localparam int CTRL_XCVR_USED = 0;
    localparam logic [NUM_BITS-1:0] STATUS_RESET = 9'h040;
    localparam logic [NUM_BITS-1:0] ENABLE_RESET = 9'h000;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int MCAST_ENTRIES = 4;
    // =========================================================
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int PHY_WAIT_US = 5000;
    localparam int PHY_WAIT_CYC = (CLK_HZ / 1_000_000) * PHY_WAIT_US;
endpackage
`default_nettype wire

// >>> design/eisl_status_latch.sv
`default_nettype none
// Contract
// - Events set status bits, held afterwards
// - Writing one clears a status bit
// - Writing zero or to clear bit: no change
// - One write clears many bits
// - Pending needs status and enable
// - Interrupt high when any pending bit
// - Bits 31 to 9 read zero
// - PHY done 5 ms after reset release
// - Transceiver ready bit per control register mode bit
// - Core accesses held until ready
// - Clock lock bit always one
// - Transmit done sets bit 5
// - Receive overflow sets bit 4
// - Bad frames set bit 3
// - Unmatched addresses set bit 3
// - Multicast reject sets bit 3
// - Broadcast reject sets bit 3
// - Receive done sets bit 2
// - Negotiation done sets bit 1
// - Core access done sets bit 0
// - Pending is status AND enable, read-only
module eisl_status_latch
    import eisl_pkg::*;
#(
    parameter int PHY_WAIT = PHY_WAIT_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    output logic irq,
    output logic phy_reset_out_n,
    output logic core_enable,
    input wire logic phy_reset_req,
    input wire logic transceiver_up,
    input wire logic tx_frame_ok,
    input wire logic rx_overflow,
    input wire logic rx_frame_end,
    input wire logic rx_frame_good,
    input wire logic rx_is_bcast,
    input wire logic rx_is_mcast,
    input wire logic rx_ucast_hit,
    input wire logic [MCAST_ENTRIES-1:0] rx_mcast_hit,
    input wire logic link_neg_ok,
    input wire logic core_access_ok
);
    // =========================================================
    // Decode
    logic wr_status, wr_enable, wr_ctrl;
    logic [NUM_BITS-1:0] status_reg, status_next, enable_reg, set_vec;
    logic [NUM_BITS-1:0] enable_next;
    logic [2:0] ctrl_reg;
    logic [31:0] cnt_reg;
    logic phy_done;
    logic rx_drop, addr_ok;

    // Address match, shared by every write decode
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Writes to the pending offset decode to nothing, so it stays read-only
    assign wr_status = wr_en && reg_hit(addr, ADDR_STATUS);
    assign wr_enable = wr_en && reg_hit(addr, ADDR_ENABLE);
    assign wr_ctrl = wr_en && reg_hit(addr, ADDR_CTRL);

    // =========================================================
    // Receive filter: reject on bad frame, address miss or type reject
    assign addr_ok = rx_ucast_hit || rx_is_bcast || (|rx_mcast_hit);
    always_comb begin
        rx_drop = 1'b0;
        if (rx_frame_end) begin
            if (!rx_frame_good) rx_drop = 1'b1;
            else if (!addr_ok) rx_drop = 1'b1;
            else if (rx_is_mcast && ctrl_reg[CTRL_MCAST_REJ]) rx_drop = 1'b1;
            else if (rx_is_bcast && ctrl_reg[CTRL_BCAST_REJ]) rx_drop = 1'b1;
        end
    end

    // =========================================================
    // PHY reset release and settle counter; PHY done bit only after wait
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phy_reset_out_n <= 1'b0;
            cnt_reg <= 32'h0;
            phy_done <= 1'b0;
        end else if (phy_reset_req) begin
            phy_reset_out_n <= 1'b0;
            cnt_reg <= 32'h0;
            phy_done <= 1'b0;
        end else begin
            phy_reset_out_n <= 1'b1;
            if (phy_reset_out_n && !phy_done) begin
                if (cnt_reg == 32'(PHY_WAIT - 1)) phy_done <= 1'b1;
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end

    // =========================================================
    // Event vector; transceiver ready follows mode strap in control
    always_comb begin
        set_vec = '0;
        set_vec[BIT_CORE_DONE] = core_access_ok;
        set_vec[BIT_NEG_DONE] = link_neg_ok;
        set_vec[BIT_RX_DONE] = rx_frame_end && !rx_drop;
        set_vec[BIT_RX_DROP] = rx_drop;
        set_vec[BIT_RX_OVF] = rx_overflow;
        set_vec[BIT_TX_DONE] = tx_frame_ok;
        set_vec[BIT_XCVR_RDY] = !ctrl_reg[CTRL_XCVR_USED] || transceiver_up;
        set_vec[BIT_PHY_DONE] = phy_done;
    end

    // Clear by one, then set wins over a clear in the same cycle
    always_comb begin
        status_next = status_reg;
        if (wr_status) status_next = status_next & ~wdata[NUM_BITS-1:0];
        status_next = status_next | set_vec;
        status_next[BIT_CLK_LOCK] = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) status_reg <= STATUS_RESET;
        else status_reg <= status_next;
    end

    // =========================================================
    // Enable and control registers
    // Next enable is exposed so the interrupt sees a new mask at once
    always_comb begin
        enable_next = enable_reg;
        if (wr_enable) enable_next = wdata[NUM_BITS-1:0];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) enable_reg <= ENABLE_RESET;
        else enable_reg <= enable_next;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) ctrl_reg <= CTRL_RESET;
        else if (wr_ctrl) ctrl_reg <= wdata[2:0];
    end

    // =========================================================
    // Interrupt and core gating, registered from next state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
            core_enable <= 1'b0;
        end else begin
            // Both next values, so irq always equals the pending read
            irq <= |(status_next & enable_next);
            core_enable <= status_next[BIT_XCVR_RDY];
        end
    end

    // =========================================================
    // Read port; pending is computed, unwritable; high bits zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) rdata <= 32'h0;
        else if (rd_en) begin
            unique case (addr)
                ADDR_STATUS: rdata <= {23'h0, status_reg};
                ADDR_ENABLE: rdata <= {23'h0, enable_reg};
                ADDR_PENDING: rdata <= {23'h0, status_reg & enable_reg};
                ADDR_CTRL: rdata <= {29'h0, ctrl_reg};
                default: rdata <= 32'h0;
            endcase
        end else rdata <= 32'h0;
    end

    // =========================================================
    // Checks
    sticky_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !wr_status |=> status_reg[BIT_TX_DONE] >= $past(status_reg[BIT_TX_DONE]))
        else $error("status bit dropped without clear");
    clear_one_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_status && wdata[BIT_RX_OVF] && !rx_overflow |=> !status_reg[BIT_RX_OVF])
        else $error("write one did not clear");
    set_wins_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        tx_frame_ok |=> status_reg[BIT_TX_DONE])
        else $error("event lost");
    irq_level_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        ##1 irq == |(status_reg & enable_reg))
        else $error("interrupt mismatch");
    lock_one_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        status_reg[BIT_CLK_LOCK])
        else $error("lock bit low");
    high_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_en |=> rdata[31:9] == 23'h0)
        else $error("reserved bits nonzero");
    phy_wait_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        phy_done |-> cnt_reg == 32'(PHY_WAIT))
        else $error("phy done early");
    core_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        core_enable |-> status_reg[BIT_XCVR_RDY])
        else $error("core enabled before ready");
    mcast_rej_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rx_frame_end && rx_frame_good && rx_is_mcast && ctrl_reg[CTRL_MCAST_REJ]
        |=> status_reg[BIT_RX_DROP])
        else $error("multicast reject not flagged");

    // =========================================================
    // Frame verdict checks, built from the frame end sequences
    sequence good_end_s;
        rx_frame_end && rx_frame_good;
    endsequence

    sequence bad_end_s;
        rx_frame_end && !rx_frame_good;
    endsequence

    sequence miss_end_s;
        rx_frame_end && rx_frame_good && !rx_ucast_hit && !rx_is_bcast && !(|rx_mcast_hit);
    endsequence

    sequence bcast_rej_s;
        rx_frame_end && rx_frame_good && rx_is_bcast && ctrl_reg[CTRL_BCAST_REJ];
    endsequence

    sequence accepted_s;
        rx_frame_end && !rx_drop;
    endsequence

    // A bad checksum or length is always a drop
    bad_frame_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        bad_end_s |=> status_reg[BIT_RX_DROP])
        else $error("bad frame not flagged");

    // No unicast, broadcast or table hit means the frame is dropped
    miss_frame_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        miss_end_s |=> status_reg[BIT_RX_DROP])
        else $error("address miss not flagged");

    bcast_rej_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        bcast_rej_s |=> status_reg[BIT_RX_DROP])
        else $error("broadcast reject not flagged");

    // Only accepted frames count as received
    rx_done_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        accepted_s |=> status_reg[BIT_RX_DONE])
        else $error("receive done not flagged");

    good_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        good_end_s ##0 !rx_drop |=> !status_reg[BIT_RX_DROP] || $past(status_reg[BIT_RX_DROP]))
        else $error("accepted frame flagged as dropped");

    // =========================================================
    // Event capture checks
    ovf_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rx_overflow |=> status_reg[BIT_RX_OVF])
        else $error("overflow lost");

    neg_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        link_neg_ok |=> status_reg[BIT_NEG_DONE])
        else $error("negotiation done lost");

    acc_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        core_access_ok |=> status_reg[BIT_CORE_DONE])
        else $error("core access done lost");

    tx_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        tx_frame_ok && !wr_status |=> status_reg[BIT_TX_DONE])
        else $error("transmit done lost");

    // =========================================================
    // Clear behaviour checks
    // Two bits cleared by one write when their sources are quiet
    clear_many_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_status && wdata[1:0] == 2'b11 && !link_neg_ok && !core_access_ok
        |=> status_reg[1:0] == 2'b00)
        else $error("multi clear failed");

    // A zero in the write leaves a set bit alone
    zero_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_status && !wdata[BIT_TX_DONE] && status_reg[BIT_TX_DONE]
        |=> status_reg[BIT_TX_DONE])
        else $error("zero write cleared a bit");

    // A one on a clear bit must not set it
    one_on_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_status && wdata[BIT_RX_OVF] && !status_reg[BIT_RX_OVF] && !rx_overflow
        |=> !status_reg[BIT_RX_OVF])
        else $error("one write set a clear bit");

    // =========================================================
    // Pending, interrupt and readiness checks
    pend_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_en && addr == ADDR_PENDING
        |=> rdata == {23'h0, $past(status_reg & enable_reg)})
        else $error("pending read mismatch");

    // With nothing enabled the line must stay low
    mask_all_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        enable_reg == '0 |-> !irq)
        else $error("interrupt with all masked");

    xcvr_free_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !ctrl_reg[CTRL_XCVR_USED] |=> status_reg[BIT_XCVR_RDY])
        else $error("ready bit late without transceiver");

    // The settle flag can never stand while the PHY is held in reset
    phy_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !phy_reset_out_n |-> !phy_done)
        else $error("phy done during reset");

    phy_req_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        phy_reset_req |=> !phy_reset_out_n && !phy_done)
        else $error("phy request ignored");
endmodule
`default_nettype wire

// >>> testbench/eisl_host_model.sv
`default_nettype none
// =========================================================
// Host side: register bus master, one-cycle strobes
module eisl_host_model (
    input wire logic ref_clk,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr_en,
    output logic rd_en,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bus idle from time zero
    initial begin
        addr = 8'h00;
        wdata = 32'h0;
        wr_en = 1'h0;
        rd_en = 1'h0;
    end
    // Released data shows the inverse so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge ref_clk);
        wr_en <= 1'h0;
        wdata <= ~d;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge ref_clk);
        rd_en <= 1'h0;
        #1;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// >>> testbench/ethernet_interrupt_status_latch_tb_top.sv
`default_nettype none
module ethernet_interrupt_status_latch_tb_top;
    import eisl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0, rstn = 1'h0, rq = 1'h0, tx = 1'h0, ovf = 1'h0, fe = 1'h0;
    logic fg = 1'h0, bc = 1'h0, mc = 1'h0, uc = 1'h0, neg = 1'h0, acc = 1'h0, xu = 1'h0;
    logic [3:0] mh = 4'h0;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v;
    logic wr_en, rd_en, irq, phy_n, core_en;
    int mismatches = 0, total_checks = 0, cyc = 0;
    logic [7:0] ft [5] = '{8'h10, 8'h0a, 8'h9c, 8'h4b, 8'h0b};
    always #25 ref_clk = ~ref_clk;
    eisl_host_model host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata));
    eisl_status_latch #(.PHY_WAIT(20)) dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
        .phy_reset_out_n(phy_n), .core_enable(core_en), .phy_reset_req(rq),
        .transceiver_up(xu), .tx_frame_ok(tx), .rx_overflow(ovf), .rx_frame_end(fe),
        .rx_frame_good(fg), .rx_is_bcast(bc), .rx_is_mcast(mc), .rx_ucast_hit(uc),
        .rx_mcast_hit(mh), .link_neg_ok(neg), .core_access_ok(acc));
    // =========================================================
    // Checking and closing
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(logic [7:0] a, logic [31:0] exp);
        host.rd(a, v);
        chk($sformatf("reg %h", a), v, exp);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Event sources pulse for one cycle together
    task automatic pulse(logic [4:0] e);
        @(posedge ref_clk);
        {tx, ovf, neg, acc, fe} <= e;
        @(posedge ref_clk);
        {tx, ovf, neg, acc, fe} <= 5'h0;
        #1;
    endtask
    // Hang guard, generous against the roughly 130 cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 5000) begin
            mismatches++;
            test_done();
        end
    end
    // =========================================================
    // Test sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'h1;
        rchk(ADDR_STATUS, 32'h0c0);
        chk("core_enable", core_en, 1'h1);
        repeat (30) @(posedge ref_clk);
        rchk(ADDR_STATUS, 32'h1c0);
        host.wr(ADDR_STATUS, 32'hfffffe40);
        rchk(ADDR_STATUS, 32'h1c0);
        rchk(8'h40, 32'h0);
        $display("test reset done");
        fg <= 1'h0;
        pulse(5'h1f);
        rchk(ADDR_STATUS, 32'h1fb);
        host.wr(ADDR_STATUS, 32'h09);
        rchk(ADDR_STATUS, 32'h1f2);
        host.wr(ADDR_STATUS, 32'h01);
        host.wr(ADDR_STATUS, 32'h0);
        rchk(ADDR_STATUS, 32'h1f2);
        $display("test clear done");
        // Frame table: ctrl field, then good, bcast, mcast, hit
        foreach (ft[i]) begin
            host.wr(ADDR_STATUS, 32'h3f);
            host.wr(ADDR_CTRL, {29'h0, ft[i][7:5]});
            {fg, bc, mc, uc} <= ft[i][3:0];
            mh <= {3'h0, ft[i][0] & ft[i][1]};
            pulse(5'h01);
            rchk(ADDR_STATUS, (i == 4) ? 32'h1c4 : 32'h1c8);
        end
        $display("test frames done");
        host.wr(ADDR_CTRL, 32'h1);
        host.wr(ADDR_STATUS, 32'h80);
        rchk(ADDR_STATUS, 32'h144);
        xu <= 1'h1;
        rchk(ADDR_STATUS, 32'h1c4);
        host.wr(ADDR_CTRL, 32'h0);
        host.wr(ADDR_ENABLE, 32'h20);
        #1 chk("irq idle", irq, 1'h0);
        pulse(5'h10);
        chk("irq set", irq, 1'h1);
        host.wr(ADDR_PENDING, 32'h0);
        rchk(ADDR_PENDING, 32'h20);
        fork
            host.wr(ADDR_STATUS, 32'h20);
            pulse(5'h10);
        join
        rchk(ADDR_STATUS, 32'h1e4);
        host.wr(ADDR_STATUS, 32'h20);
        #1 chk("irq clear", irq, 1'h0);
        pulse(5'h10);
        host.wr(ADDR_ENABLE, 32'h0);
        #1 chk("irq masked", irq, 1'h0);
        rchk(ADDR_PENDING, 32'h0);
        $display("test pending done");
        test_done();
    end
endmodule
`default_nettype wire
